// *** rtl/ppc_pkg.sv ***
package ppc_pkg;

  // ----------------------------------------------------------------
  // Register map and bus answers
  // ----------------------------------------------------------------
  localparam int unsigned AXI_DATA_W      = 32;
  localparam int unsigned AXI_ADDR_W      = 4;
  localparam logic [3:0]  CTRL_OFF        = 4'h0;  // Control: guard enable, mask bit 00
  localparam logic [3:0]  STAT_OFF        = 4'h4;  // Status: sticky flags, write 1 to clear
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_DECERR     = 2'h3;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_GUARD_POS  = 0;
  localparam int unsigned CTRL_MASK0_POS  = 1;
  localparam int unsigned STAT_FAULT_POS  = 0;
  localparam int unsigned STAT_PARITY_POS = 1;
  localparam int unsigned STAT_PROT_POS   = 2;
  localparam logic        CTRL_GUARD_RST  = 1'b0;
  localparam logic        CTRL_MASK0_RST  = 1'b0;
  localparam logic        FLAG_RST        = 1'b0;

  // ----------------------------------------------------------------
  // Storage word layout
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W_DEF      = 18;
  localparam int unsigned GUARD_POS_DEF   = 17;

  // ----------------------------------------------------------------
  // Instruction classes reported by the sequencer at each fetch
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_PLAIN                  = 3'h0,
    OP_INTERREG_BIT0          = 3'h1,
    OP_INTERRUPT_ENABLE_INSTR = 3'h2,
    OP_INTERRUPT_INHIBIT_INSTR = 3'h3,
    OP_INTERRUPT_EXIT_INSTR   = 3'h4,
    OP_SET_GUARD_BIT_INSTR    = 3'h5,
    OP_CLEAR_GUARD_BIT_INSTR  = 3'h6
  } ppc_op_type;

  // True for classes that only a protected program may run
  function automatic logic ppc_is_restricted(input ppc_op_type op);
    return (op == OP_INTERREG_BIT0) || (op == OP_INTERRUPT_ENABLE_INSTR) ||
           (op == OP_INTERRUPT_INHIBIT_INSTR) || (op == OP_INTERRUPT_EXIT_INSTR) ||
           (op == OP_SET_GUARD_BIT_INSTR) || (op == OP_CLEAR_GUARD_BIT_INSTR);
  endfunction

endpackage

// *** rtl/ppc_reg_if.sv ***
`timescale 1ns/1ps
// Register access between the bus engine and the checker core
interface ppc_reg_if;
  import ppc_pkg::*;
  logic                    wr_en;
  logic [AXI_ADDR_W-1:0]   wr_addr;
  logic [AXI_DATA_W-1:0]   wr_data;
  logic [3:0]              wr_strb;
  logic                    wr_ok;
  logic [AXI_ADDR_W-1:0]   rd_addr;
  logic [AXI_DATA_W-1:0]   rd_data;
  logic                    rd_ok;

  modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_addr, input wr_ok, rd_data, rd_ok);
  modport core (input wr_en, wr_addr, wr_data, wr_strb, rd_addr, output wr_ok, rd_data, rd_ok);
endinterface

// *** rtl/ppc_axil_regs.sv ***
`timescale 1ns/1ps
// AXI4-Lite slave engine; the core decodes and answers over the interface
module ppc_axil_regs
  import ppc_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [AXI_ADDR_W-1:0] awaddr,
  input  wire logic                  awvalid,
  output      logic                  awready,
  input  wire logic [AXI_DATA_W-1:0] wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output      logic                  wready,
  output      logic [1:0]            bresp,
  output      logic                  bvalid,
  input  wire logic                  bready,
  input  wire logic [AXI_ADDR_W-1:0] araddr,
  input  wire logic                  arvalid,
  output      logic                  arready,
  output      logic [AXI_DATA_W-1:0] rdata,
  output      logic [1:0]            rresp,
  output      logic                  rvalid,
  input  wire logic                  rready,
  ppc_reg_if.bus                     rif
);

  logic                  aw_have_q;
  logic                  w_have_q;
  logic [AXI_ADDR_W-1:0] awaddr_q;
  logic [AXI_DATA_W-1:0] wdata_q;
  logic [3:0]            wstrb_q;

  // ----------------------------------------------------------------
  // Handshakes: each channel is held off while its slot is full
  // ----------------------------------------------------------------
  assign awready     = !aw_have_q && !bvalid;
  assign wready      = !w_have_q && !bvalid;
  assign arready     = !rvalid;
  assign rif.wr_en   = aw_have_q && w_have_q && !bvalid;
  assign rif.wr_addr = awaddr_q;
  assign rif.wr_data = wdata_q;
  assign rif.wr_strb = wstrb_q;
  assign rif.rd_addr = araddr;

  // Write path: collect address and data in either order, then answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= awaddr;
      end
      if (wvalid && wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= wdata;
        wstrb_q  <= wstrb;
      end
      if (rif.wr_en) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= rif.wr_ok ? RESP_OKAY : RESP_DECERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read path: answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rif.rd_data;
      rresp  <= rif.rd_ok ? RESP_OKAY : RESP_DECERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule // ppc_axil_regs

// *** rtl/ppc_checker.sv ***
`timescale 1ns/1ps
// Contract
// - Protected fetch right after nonprotected execution is a violation, run as nonprotected stop.
// - That transition is no violation when interrupt entry caused it.
// - Unprotected interregister-bit0 or the five privileged instructions: violation, become stop.
// - Nonprotected write with parity error present or occurring: word kept, parity flag raised.
// - Protected write with parity error: word still written, parity flag raised.
// - Guard-bit set or clear meeting parity error becomes a pass, parity flag raised.
// - Interrupt conditions sampled at each instruction fetch, taken at that cycle's end.
// - Single-cycle instruction completes before a pending interrupt is taken.
// - Multi-cycle instruction is abandoned when an interrupt is taken.
// - Write and transition faults are taken after the next instruction fetch.
// - Privileged-instruction fault is taken after the same fetch cycle.
// - Bit 17 of every storage word marks it protected when set.
// - Nonprotected write into a protected word is a violation and leaves the word.
// - Any violation sets the fault flag; interrupt 00 needs mask bit 00 and active system.
// - With the guard switch off no violations are recognised.
module ppc_checker
  import ppc_pkg::*;
#(
  parameter int unsigned WORD_W    = WORD_W_DEF,
  parameter int unsigned GUARD_POS = GUARD_POS_DEF
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output      logic                  s_axi_awready,
  input  wire logic [AXI_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output      logic                  s_axi_wready,
  output      logic [1:0]            s_axi_bresp,
  output      logic                  s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output      logic                  s_axi_arready,
  output      logic [AXI_DATA_W-1:0] s_axi_rdata,
  output      logic [1:0]            s_axi_rresp,
  output      logic                  s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  fetch_stb,
  input  wire logic [WORD_W-1:0]     fetch_word,
  input  wire ppc_op_type            fetch_op,
  input  wire logic                  fetch_multi,
  input  wire logic                  fetch_after_int,
  input  wire logic                  fetch_parity_err,
  input  wire logic                  ext_int_req,
  input  wire logic                  int_active,
  input  wire logic                  store_stb,
  input  wire logic [WORD_W-1:0]     store_old_word,
  input  wire logic                  store_guard_op,
  input  wire logic                  store_parity_err,
  output      logic                  exec_stop,
  output      logic                  take_int,
  output      logic                  abandon,
  output      logic                  store_allow,
  output      logic                  store_block,
  output      logic                  guard_op_pass,
  output      logic                  fault_flag,
  output      logic                  parity_flag
);

  if (GUARD_POS >= WORD_W) begin : g_bad_word
    $error("GUARD_POS must lie inside the storage word");
  end

  ppc_reg_if rif ();

  ppc_axil_regs u_regs (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .rif     (rif)
  );

  logic guard_en_q;
  logic mask0_q;
  logic fault_q;
  logic parity_q;
  logic exec_prot_q;
  logic exec_stop_q;
  logic take_q;
  logic abandon_q;
  logic allow_q;
  logic block_q;
  logic pass_q;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  logic wr_ctrl;
  logic wr_stat;
  logic fault_clr;
  logic parity_clr;

  assign wr_ctrl    = rif.wr_en && (rif.wr_addr == CTRL_OFF) && rif.wr_strb[0];
  assign wr_stat    = rif.wr_en && (rif.wr_addr == STAT_OFF) && rif.wr_strb[0];
  assign fault_clr  = wr_stat && rif.wr_data[STAT_FAULT_POS];
  assign parity_clr = wr_stat && rif.wr_data[STAT_PARITY_POS];
  assign rif.wr_ok  = (rif.wr_addr == CTRL_OFF) || (rif.wr_addr == STAT_OFF);

  // Read mux: unused bits read as zero
  always_comb begin
    rif.rd_data = '0;
    rif.rd_ok   = 1'b1;
    if (rif.rd_addr == CTRL_OFF) begin
      rif.rd_data[CTRL_GUARD_POS] = guard_en_q;
      rif.rd_data[CTRL_MASK0_POS] = mask0_q;
    end else if (rif.rd_addr == STAT_OFF) begin
      rif.rd_data[STAT_FAULT_POS]  = fault_q;
      rif.rd_data[STAT_PARITY_POS] = parity_q;
      rif.rd_data[STAT_PROT_POS]   = exec_prot_q;
    end else begin
      rif.rd_ok = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Fetch checks
  // ----------------------------------------------------------------
  logic fetch_prot;
  logic viol_trans;
  logic viol_priv;
  logic int_cond;

  assign fetch_prot = fetch_word[GUARD_POS];
  // Transition unless interrupt entry produced it; nothing when the switch is off
  assign viol_trans = fetch_stb && guard_en_q && fetch_prot && !exec_prot_q
                      && !fetch_after_int;
  assign viol_priv  = fetch_stb && guard_en_q && !fetch_prot
                      && ppc_is_restricted(fetch_op);
  // Privileged fault joins sampling now; stored flags were set by earlier cycles
  assign int_cond   = ext_int_req || (int_active && mask0_q
                      && (fault_q || parity_q || viol_priv));

  // ----------------------------------------------------------------
  // Store checks
  // ----------------------------------------------------------------
  logic viol_store;
  logic par_block;
  logic pass_now;
  logic blk_now;

  assign viol_store = store_stb && guard_en_q && !exec_prot_q
                      && store_old_word[GUARD_POS];
  assign par_block  = store_stb && !exec_prot_q
                      && (store_parity_err || parity_q);
  assign pass_now   = store_stb && store_guard_op && store_parity_err;
  assign blk_now    = viol_store || par_block || pass_now;

  // Control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      guard_en_q <= CTRL_GUARD_RST;
      mask0_q    <= CTRL_MASK0_RST;
    end else if (wr_ctrl) begin
      guard_en_q <= rif.wr_data[CTRL_GUARD_POS];
      mask0_q    <= rif.wr_data[CTRL_MASK0_POS];
    end
  end

  // Sticky flags: a new event wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_q  <= FLAG_RST;
      parity_q <= FLAG_RST;
    end else begin
      fault_q  <= viol_trans || viol_priv || viol_store || (fault_q && !fault_clr);
      parity_q <= (store_stb && store_parity_err) || (fetch_stb && fetch_parity_err)
                  || (parity_q && !parity_clr);
    end
  end

  // Protection of the instruction now executing; a demoted one runs nonprotected
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      exec_prot_q <= 1'b0;
    end else if (fetch_stb) begin
      exec_prot_q <= fetch_prot && !viol_trans;
    end
  end

  // Answers, one cycle after the strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      exec_stop_q <= 1'b0;
      take_q      <= 1'b0;
      abandon_q   <= 1'b0;
      allow_q     <= 1'b0;
      block_q     <= 1'b0;
      pass_q      <= 1'b0;
    end else begin
      exec_stop_q <= viol_trans || viol_priv;
      take_q      <= fetch_stb && int_cond;
      abandon_q   <= fetch_stb && int_cond && fetch_multi;
      allow_q     <= store_stb && !blk_now;
      block_q     <= blk_now;
      pass_q      <= pass_now;
    end
  end

  assign exec_stop     = exec_stop_q;
  assign take_int      = take_q;
  assign abandon       = abandon_q;
  assign store_allow   = allow_q;
  assign store_block   = block_q;
  assign guard_op_pass = pass_q;
  assign fault_flag    = fault_q;
  assign parity_flag   = parity_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_unprot_exec;
    fetch_stb && !fetch_word[GUARD_POS] && !ppc_is_restricted(fetch_op) && guard_en_q;
  endsequence

  sequence s_prot_fetch_plain;
    fetch_stb && fetch_word[GUARD_POS] && !fetch_after_int && guard_en_q;
  endsequence

  // Fault set now, or one cycle with no clear before an interrupt-enabled fetch
  sequence s_fault_set;
    viol_trans || viol_store;
  endsequence

  sequence s_int_fetch;
    fetch_stb && int_active && mask0_q;
  endsequence

  // The protected fetch may follow at once or after one idle cycle
  AST_TRANSITION_STOP: assert property (
    (s_unprot_exec ##1 s_prot_fetch_plain) or (s_unprot_exec ##1 !fetch_stb ##1 s_prot_fetch_plain)
    |=> exec_stop && fault_flag && !exec_prot_q)
    else $error("protected fetch after nonprotected did not stop");

  AST_ENTRY_EXEMPT: assert property (
    fetch_stb && fetch_word[GUARD_POS] && fetch_after_int |=> !exec_stop && exec_prot_q)
    else $error("interrupt entry transition was flagged");

  AST_PRIV_STOP: assert property (
    fetch_stb && guard_en_q && !fetch_word[GUARD_POS] && ppc_is_restricted(fetch_op)
    |=> exec_stop && fault_flag)
    else $error("unprotected privileged instruction not stopped");

  AST_UNPROT_PARITY: assert property (
    store_stb && !exec_prot_q && store_parity_err |=> store_block && !store_allow && parity_flag)
    else $error("nonprotected write with parity error not blocked");

  AST_PROT_PARITY: assert property (
    store_stb && exec_prot_q && store_parity_err && !store_guard_op
    |=> store_allow && parity_flag)
    else $error("protected write with parity error was blocked");

  AST_GUARD_PASS: assert property (
    store_stb && store_guard_op && store_parity_err |=> guard_op_pass && store_block)
    else $error("guard bit op with parity error not turned into pass");

  AST_FAULT_SET: assert property (
    viol_trans || viol_priv || viol_store |=> fault_flag)
    else $error("violation did not set the fault flag");

  AST_FAULT_NEXT_FETCH: assert property (
    (s_fault_set ##1 s_int_fetch) or
    (s_fault_set ##1 !fault_clr ##1 s_int_fetch) |=> take_int)
    else $error("pending fault not taken after next fetch");

  AST_PRIV_SAME_CYCLE: assert property (
    viol_priv && int_active && mask0_q |=> take_int)
    else $error("privileged fault not taken after same cycle");

  AST_MULTI_ABANDON: assert property (
    take_int |-> (abandon == $past(fetch_multi)))
    else $error("abandon does not follow instruction length");

  AST_SWITCH_OFF: assert property (
    !guard_en_q && !store_parity_err && !parity_q && store_stb |=> store_allow)
    else $error("write refused with guard switch off");

  AST_NO_INT_MASKED: assert property (
    fetch_stb && !ext_int_req && !mask0_q |=> !take_int)
    else $error("interrupt taken with mask bit 00 clear");

endmodule // ppc_checker

// *** bench/ppc_seq_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Sequencer and core storage stand-in
// ----------------------------------------------------------------
module ppc_seq_model
  import ppc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        store_allow,
  output      logic        fetch_stb,
  output      logic [17:0] fetch_word,
  output      ppc_op_type  fetch_op,
  output      logic        fetch_multi,
  output      logic        fetch_after_int,
  output      logic        fetch_parity_err,
  output      logic        ext_int_req,
  output      logic        store_stb,
  output      logic [17:0] store_old_word,
  output      logic        store_guard_op,
  output      logic        store_parity_err
);
  logic [17:0] cell_q = 18'h00000;
  logic [17:0] new_q;

  // Protected peripheral answer: reject only unguarded non-status commands
  function automatic logic periph_reject(input logic sw_on, input logic prot_cmd, input logic status_req);
    return sw_on && !prot_cmd && !status_req;
  endfunction

  // Storage cell changes only on an allowed write
  always @(posedge aclk) begin
    if (store_allow) begin
      cell_q <= new_q;
    end
  end

  // Quiet lines at time zero
  initial begin
    {fetch_stb, fetch_multi, fetch_after_int, fetch_parity_err, ext_int_req} = 5'h00;
    {store_stb, store_guard_op, store_parity_err} = 3'h0;
    fetch_word     = 18'h00000;
    store_old_word = 18'h00000;
    fetch_op       = OP_PLAIN;
    new_q          = 18'h00000;
  end

  // One instruction word read; the word line is scrambled once released
  task automatic fetch(input logic p, input ppc_op_type op, input logic ai, input logic mc, input logic ex);
    @(posedge aclk);
    fetch_stb       <= 1'b1;
    fetch_word      <= {p, 17'h00041};
    fetch_op        <= op;
    fetch_after_int <= ai;
    fetch_multi     <= mc;
    ext_int_req     <= ex;
    @(posedge aclk);
    fetch_stb       <= 1'b0;
    fetch_word      <= ~fetch_word;
    #1;
  endtask

  // One storage write attempt against the cell
  task automatic store(input logic [17:0] nw, input logic go, input logic pe);
    @(posedge aclk);
    store_stb        <= 1'b1;
    store_old_word   <= cell_q;
    new_q            <= nw;
    store_guard_op   <= go;
    store_parity_err <= pe;
    @(posedge aclk);
    store_stb        <= 1'b0;
    store_old_word   <= ~cell_q;
    #1;
  endtask
endmodule // ppc_seq_model

// *** bench/program_protect_checker_test.sv ***
`timescale 1ns/1ps
module program_protect_checker_test;
  import ppc_pkg::*;
  localparam logic L = 1'b0;
  localparam logic H = 1'b1;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, int_active;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         fetch_stb, fetch_multi, fetch_after_int, fetch_parity_err, ext_int_req;
  wire         store_stb, store_guard_op, store_parity_err;
  wire  [17:0] fetch_word, store_old_word;
  ppc_op_type  fetch_op;
  wire         exec_stop, take_int, abandon, store_allow, store_block, guard_op_pass, fault_flag, parity_flag;
  int          err_count = 0;
  int          check_count = 0;
  int          cyc = 0;

  ppc_checker #(.WORD_W(18), .GUARD_POS(17)) dut_u (.*);
  ppc_seq_model m_u (.*);

  // 50 MHz clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // Cut a hung run short
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // Compare, report and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s exp %0h got %0h", n, e, g);
    end
  endtask

  task automatic chkw(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s exp %0h got %0h", n, e, g);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
  endtask

  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chkw("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
  endtask

  // Fetch one word and judge the three fetch answers
  task automatic fc(input logic p, input ppc_op_type op, input logic ai, mc, ex, es, ti, ab);
    m_u.fetch(p, op, ai, mc, ex);
    chk("exec_stop", es, exec_stop);
    chk("take_int", ti, take_int);
    chk("abandon", ab, abandon);
  endtask

  // Attempt one write, judge the answers and the stored word
  task automatic sc(input logic [17:0] nw, input logic go, pe, al, bl, gp, input logic [17:0] ce);
    m_u.store(nw, go, pe);
    chk("store_allow", al, store_allow);
    chk("store_block", bl, store_block);
    chk("guard_op_pass", gp, guard_op_pass);
    @(posedge aclk);
    #1;
    chkw("stored_word", {14'h0, ce}, {14'h0, m_u.cell_q});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    axr(CTRL_OFF, d, r);
    chkw("ctrl_rst", 32'h00000000, d);
    axr(STAT_OFF, d, r);
    chkw("stat_rst", 32'h00000000, d);
    axr(4'h8, d, r);
    chkw("rresp", {30'h0, RESP_DECERR}, {30'h0, r});
    axw(4'hC, 32'h00000003, r);
    chkw("bresp", {30'h0, RESP_DECERR}, {30'h0, r});
    wr(CTRL_OFF, 32'h00000003);
    axr(CTRL_OFF, d, r);
    chkw("ctrl", 32'h00000003, d);
  endtask

  task automatic t_trans;
    logic [31:0] d;
    logic [1:0]  r;
    fc(L, OP_PLAIN, L, L, L, L, L, L);
    fc(H, OP_PLAIN, L, L, L, H, L, L);
    chk("fault_flag", H, fault_flag);
    fc(L, OP_PLAIN, L, L, L, L, H, L);
    axr(STAT_OFF, d, r);
    chkw("stat_fault", 32'h00000001, d);
    wr(STAT_OFF, 32'h00000003);
    fc(L, OP_PLAIN, L, L, L, L, L, L);
    fc(H, OP_PLAIN, H, L, L, L, L, L);
    chk("fault_flag", L, fault_flag);
    axr(STAT_OFF, d, r);
    chkw("stat_prot", 32'h00000004, d);
    fc(H, OP_INTERRUPT_EXIT_INSTR, L, L, L, L, L, L);
  endtask

  task automatic t_priv;
    for (int i = 1; i < 7; i++) begin
      fc(L, ppc_op_type'(i[2:0]), L, L, L, H, H, L);
      wr(STAT_OFF, 32'h00000003);
    end
    wr(CTRL_OFF, 32'h00000001);
    fc(L, OP_SET_GUARD_BIT_INSTR, L, L, L, H, L, L);
    chk("fault_flag", H, fault_flag);
    wr(STAT_OFF, 32'h00000003);
    wr(CTRL_OFF, 32'h00000002);
    fc(L, OP_PLAIN, L, L, L, L, L, L);
    fc(H, OP_PLAIN, L, L, L, L, L, L);
    fc(L, OP_INTERREG_BIT0, L, L, L, L, L, L);
    sc(18'h20001, L, L, H, L, L, 18'h20001);
    sc(18'h00002, L, L, H, L, L, 18'h00002);
    chk("fault_flag", L, fault_flag);
    wr(CTRL_OFF, 32'h00000003);
  endtask

  task automatic t_store;
    fc(H, OP_PLAIN, H, L, L, L, L, L);
    sc(18'h20005, L, L, H, L, L, 18'h20005);
    fc(L, OP_PLAIN, L, L, L, L, L, L);
    sc(18'h00007, L, L, L, H, L, 18'h20005);
    chk("fault_flag", H, fault_flag);
    wr(STAT_OFF, 32'h00000003);
    fc(H, OP_PLAIN, H, L, L, L, L, L);
    sc(18'h00003, L, L, H, L, L, 18'h00003);
    fc(L, OP_PLAIN, L, L, L, L, L, L);
    sc(18'h00009, L, H, L, H, L, 18'h00003);
    chk("parity_flag", H, parity_flag);
    sc(18'h0000A, L, L, L, H, L, 18'h00003);
    wr(STAT_OFF, 32'h00000003);
    fc(H, OP_PLAIN, H, L, L, L, L, L);
    sc(18'h0000B, L, H, H, L, L, 18'h0000B);
    chk("parity_flag", H, parity_flag);
    sc(18'h2000C, H, H, L, H, H, 18'h0000B);
    chk("parity_flag", H, parity_flag);
    wr(STAT_OFF, 32'h00000003);
  endtask

  task automatic t_ext;
    wr(CTRL_OFF, 32'h00000000);
    fc(H, OP_PLAIN, H, L, H, L, H, L);
    fc(H, OP_PLAIN, L, H, H, L, H, H);
    fc(H, OP_PLAIN, L, H, L, L, L, L);
    wr(CTRL_OFF, 32'h00000003);
    int_active <= 1'b0;
    fc(L, OP_INTERREG_BIT0, L, L, L, H, L, L);
    chk("periph_nonprot", H, m_u.periph_reject(H, L, L));
    chk("periph_status", L, m_u.periph_reject(H, L, H));
    chk("periph_prot", L, m_u.periph_reject(H, H, L));
    chk("periph_off", L, m_u.periph_reject(L, L, L));
  endtask

  // Reset, then run every scenario
  initial begin
    aresetn = 1'b0;
    int_active = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 4'h0;
    s_axi_araddr = 4'h0;
    s_axi_wstrb = 4'hF;
    s_axi_wdata = 32'h00000000;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_trans();
    t_priv();
    t_store();
    t_ext();
    complete_run();
  end
endmodule // program_protect_checker_test
